/* File: rtl/timer8_waveform_output_control.v */
`timescale 1ns/1ps
`include "timer8_waveform_regs.vh"

//Operation
// - Nonzero mode A puts wave A on pin, except PWM mode 01 without bit2
// - Nonzero mode B puts wave B on pin
// - Pin driven only when direction bit set
// - Non-PWM A: off, toggle, clear, set
// - Non-PWM B: same encoding as A
// - Fast PWM A: match and TOP actions
// - PWM A mode 01 toggles if bit2
// - Fast PWM B: 01 reserved, 10/11 actions
// - Phase PWM A: up/down match actions
// - Phase PWM B: 01 reserved, up/down actions
// - Compare equals TOP: act at TOP
// - Bits 3 and 2 read zero
// - Mode field selects counter operation
// - TOP is 0xff or compare A
// - PWM compare writes buffered to TOP
// - Overflow flag set point per mode
// - Mode bit 2 in control B bit 3
module timer8_waveform_output_control (
    input wire clk_i, // System clock, 20 MHz.
    input wire rst_i, // Synchronous reset, active high.
    input wire [2:0] addr_i, // Register index.
    input wire [7:0] wdata_i, // Write data.
    input wire wr_i, // Write strobe.
    input wire rd_i, // Read strobe.
    input wire [7:0] port_a_i, // Normal port value for the A pin.
    input wire [7:0] port_b_i, // Normal port value for the B pin.
    output reg [7:0] rdata_o, // Read data, valid the cycle after rd_i.
    output reg pin_a_o, // Level of the A pin.
    output reg pin_a_oe_n_o, // A pin driver enable, low while driving.
    output reg pin_b_o, // Level of the B pin.
    output reg pin_b_oe_n_o, // B pin driver enable, low while driving.
    output reg waveform_out_a_o, // Internal waveform A level.
    output reg waveform_out_b_o // Internal waveform B level.
);
    localparam KIND_PLAIN = 2'h0;
    localparam KIND_FAST = 2'h1;
    localparam KIND_PHASE = 2'h2;

    reg [7:0] control_a_reg;
    reg [7:0] control_b_reg;
    reg [7:0] counter_reg;
    reg [7:0] counter_next;
    reg [7:0] compare_a_buf_reg;
    reg [7:0] compare_b_buf_reg;
    reg [7:0] compare_a_reg;
    reg [7:0] compare_b_reg;
    reg [2:0] status_reg;
    reg [1:0] direction_reg;
    reg down_reg;
    reg down_next;
    reg ovf_set;
    reg [7:0] top_value;
    reg [1:0] kind;
    reg [7:0] read_value;

    wire [2:0] waveform_mode_field;
    wire [1:0] compare_output_mode_a;
    wire [1:0] compare_output_mode_b;
    wire tick;
    wire at_top;
    wire wave_a;
    wire wave_b;
    wire match_a;
    wire match_b;
    wire count_write;

    // Mode bit 2 lives in control B; the low bits here.
    assign waveform_mode_field = {control_b_reg[`CTLB_WGM2], control_a_reg[1:0]};
    assign compare_output_mode_a = control_a_reg[`CTLA_COM_A_HI:`CTLA_COM_A_LO];
    assign compare_output_mode_b = control_a_reg[`CTLA_COM_B_HI:`CTLA_COM_B_LO];
    // Without a prescaler the timer clock enable is the run bit itself.
    assign tick = control_b_reg[`CTLB_RUN];
    assign at_top = (counter_reg == top_value);
    assign count_write = wr_i && (addr_i == `ADDR_COUNTER);
    // A counter write blocks the match in the same cycle as the write.
    assign match_a = (counter_reg == compare_a_reg) && !count_write;
    assign match_b = (counter_reg == compare_b_reg) && !count_write;

    // Decode operation kind and TOP from the mode field.
    always @* begin
        case (waveform_mode_field)
            3'h1, 3'h5: kind = KIND_PHASE;
            3'h3, 3'h7: kind = KIND_FAST;
            default: kind = KIND_PLAIN;
        endcase
        case (waveform_mode_field)
            3'h2, 3'h5, 3'h7: top_value = compare_a_reg;
            default: top_value = `COUNT_MAX;
        endcase
    end

    // Counter sequence and overflow set point for each mode.
    always @* begin
        counter_next = counter_reg;
        down_next = down_reg;
        ovf_set = 1'b0;
        if (tick) begin
            case (kind)
                KIND_PHASE: begin
                    if (!down_reg && at_top) begin
                        down_next = 1'b1;
                        counter_next = counter_reg - 8'h01;
                    end else if (down_reg && counter_reg == `COUNT_BOTTOM) begin
                        down_next = 1'b0;
                        counter_next = counter_reg + 8'h01;
                        ovf_set = 1'b1;
                    end else if (down_reg) begin
                        counter_next = counter_reg - 8'h01;
                    end else begin
                        counter_next = counter_reg + 8'h01;
                    end
                end
                default: begin
                    down_next = 1'b0;
                    if (at_top) begin
                        counter_next = `COUNT_BOTTOM;
                    end else begin
                        counter_next = counter_reg + 8'h01;
                    end
                    if (waveform_mode_field == 3'h7) begin
                        ovf_set = at_top;
                    end else begin
                        ovf_set = (counter_reg == `COUNT_MAX);
                    end
                end
            endcase
        end
    end

    // Register file writes, counter and compare update.
    always @(posedge clk_i) begin
        if (rst_i) begin
            control_a_reg <= `RESET_BYTE;
            control_b_reg <= `RESET_BYTE;
            counter_reg <= `RESET_BYTE;
            compare_a_buf_reg <= `RESET_BYTE;
            compare_b_buf_reg <= `RESET_BYTE;
            compare_a_reg <= `RESET_BYTE;
            compare_b_reg <= `RESET_BYTE;
            status_reg <= 3'h0;
            direction_reg <= 2'h0;
            down_reg <= 1'b0;
        end else begin
            counter_reg <= counter_next;
            down_reg <= down_next;
            // Flags set by hardware win over a write-one clear.
            status_reg <= (status_reg & ~((wr_i && addr_i == `ADDR_STATUS) ?
                wdata_i[2:0] : 3'h0)) | {tick && match_b, tick && match_a, ovf_set};
            if (wr_i) begin
                case (addr_i)
                    `ADDR_CONTROL_A: control_a_reg <= wdata_i & `CTLA_WRITE_MASK;
                    `ADDR_CONTROL_B: control_b_reg <= wdata_i & `CTLB_WRITE_MASK;
                    `ADDR_COUNTER: counter_reg <= wdata_i;
                    `ADDR_COMPARE_A: compare_a_buf_reg <= wdata_i;
                    `ADDR_COMPARE_B: compare_b_buf_reg <= wdata_i;
                    `ADDR_DIRECTION: direction_reg <= wdata_i[1:0];
                    default: ;
                endcase
            end
            // Non-PWM modes update at once; PWM modes only at TOP.
            if (kind == KIND_PLAIN) begin
                if (wr_i && addr_i == `ADDR_COMPARE_A) begin
                    compare_a_reg <= wdata_i;
                end else begin
                    compare_a_reg <= compare_a_buf_reg;
                end
                if (wr_i && addr_i == `ADDR_COMPARE_B) begin
                    compare_b_reg <= wdata_i;
                end else begin
                    compare_b_reg <= compare_b_buf_reg;
                end
            end else if (tick && at_top) begin
                compare_a_reg <= compare_a_buf_reg;
                compare_b_reg <= compare_b_buf_reg;
            end
        end
    end

    // Read mux; unmapped indices read zero.
    always @* begin
        case (addr_i)
            `ADDR_CONTROL_A: read_value = control_a_reg & `CTLA_WRITE_MASK;
            `ADDR_CONTROL_B: read_value = control_b_reg;
            `ADDR_COUNTER: read_value = counter_reg;
            `ADDR_COMPARE_A: read_value = compare_a_buf_reg;
            `ADDR_COMPARE_B: read_value = compare_b_buf_reg;
            `ADDR_STATUS: read_value = {5'h00, status_reg};
            `ADDR_DIRECTION: read_value = {6'h00, direction_reg};
            default: read_value = 8'h00;
        endcase
    end

    // Channel A waveform generator.
    timer8_channel_out chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .mode_i(compare_output_mode_a),
        .is_chan_a_i(1'b1),
        .kind_i(kind),
        .wgm2_i(waveform_mode_field[2]),
        .match_i(match_a),
        .at_top_i(at_top),
        .down_i(down_reg),
        .cmp_is_top_i(compare_a_reg == top_value),
        .wave_o(wave_a)
    );

    // Channel B waveform generator.
    timer8_channel_out chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .mode_i(compare_output_mode_b),
        .is_chan_a_i(1'b0),
        .kind_i(kind),
        .wgm2_i(waveform_mode_field[2]),
        .match_i(match_b),
        .at_top_i(at_top),
        .down_i(down_reg),
        .cmp_is_top_i(compare_b_reg == top_value),
        .wave_o(wave_b)
    );

    // Pin override and driver enable, all registered outputs.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            pin_a_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_a_oe_n_o <= 1'b1;
            pin_b_oe_n_o <= 1'b1;
            waveform_out_a_o <= 1'b0;
            waveform_out_b_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? read_value : 8'h00;
            waveform_out_a_o <= wave_a;
            waveform_out_b_o <= wave_b;
            // In PWM, mode 01 on A without bit 2 leaves the pin to the port.
            if ((compare_output_mode_a == 2'h1) && (kind != KIND_PLAIN) &&
                !waveform_mode_field[2]) begin
                pin_a_o <= port_a_i[0];
            end else begin
                pin_a_o <= (|compare_output_mode_a) ? wave_a : port_a_i[0];
            end
            pin_b_o <= (|compare_output_mode_b) ? wave_b : port_b_i[0];
            pin_a_oe_n_o <= ~direction_reg[`DIR_A];
            pin_b_oe_n_o <= ~direction_reg[`DIR_B];
        end
    end
endmodule

/* File: rtl/timer8_waveform_regs.vh */
`ifndef TIMER8_WAVEFORM_REGS_VH
`define TIMER8_WAVEFORM_REGS_VH
// Register indices on the plain register port.
`define ADDR_CONTROL_A 3'h0
`define ADDR_CONTROL_B 3'h1
`define ADDR_COUNTER 3'h2
`define ADDR_COMPARE_A 3'h3
`define ADDR_COMPARE_B 3'h4
`define ADDR_STATUS 3'h5
`define ADDR_DIRECTION 3'h6
// Field positions of the waveform control register A.
`define CTLA_COM_A_HI 7
`define CTLA_COM_A_LO 6
`define CTLA_COM_B_HI 5
`define CTLA_COM_B_LO 4
`define CTLA_WRITE_MASK 8'hf3
// Field positions of control register B.
`define CTLB_WGM2 3
`define CTLB_RUN 0
`define CTLB_WRITE_MASK 8'h09
// Status and direction bits.
`define STAT_OVF 0
`define STAT_MATCH_A 1
`define STAT_MATCH_B 2
`define DIR_A 0
`define DIR_B 1
// Reset values and fixed counter points.
`define RESET_BYTE 8'h00
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`endif

/* File: rtl/timer8_channel_out.v */
`timescale 1ns/1ps
`include "timer8_waveform_regs.vh"

// One compare output channel: decodes its compare-output mode into set, clear or toggle.
module timer8_channel_out (
    input wire clk_i, // System clock.
    input wire rst_i, // Synchronous reset, active high.
    input wire tick_i, // Timer clock enable.
    input wire [1:0] mode_i, // Compare-output mode of this channel.
    input wire is_chan_a_i, // High for channel A, which owns mode 01 toggle in PWM.
    input wire [1:0] kind_i, // 0 non-PWM, 1 fast PWM, 2 phase-correct.
    input wire wgm2_i, // Waveform mode bit 2.
    input wire match_i, // Counter equals active compare value.
    input wire at_top_i, // Counter is at TOP.
    input wire down_i, // Phase-correct counter is counting down.
    input wire cmp_is_top_i, // Active compare value equals TOP.
    output reg wave_o // Waveform output level.
);
    localparam KIND_PLAIN = 2'h0;
    localparam KIND_FAST = 2'h1;
    localparam KIND_PHASE = 2'h2;

    reg wave_next;
    reg hit;

    // Special case: in PWM modes, with compare at TOP and high mode bit set, the match is dropped.
    always @* begin
        hit = tick_i && match_i;
        wave_next = wave_o;
        if ((kind_i != KIND_PLAIN) && mode_i[1] && cmp_is_top_i) begin
            hit = 1'b0;
        end
        case (kind_i)
            KIND_PLAIN: begin
                if (hit) begin
                    case (mode_i)
                        2'h1: wave_next = ~wave_o;
                        2'h2: wave_next = 1'b0;
                        2'h3: wave_next = 1'b1;
                        default: wave_next = wave_o;
                    endcase
                end
            end
            KIND_FAST: begin
                if (mode_i == 2'h1) begin
                    if (hit && is_chan_a_i && wgm2_i) begin
                        wave_next = ~wave_o;
                    end
                end else if (mode_i[1]) begin
                    if (tick_i && at_top_i) begin
                        wave_next = ~mode_i[0];
                    end else if (hit) begin
                        wave_next = mode_i[0];
                    end
                end
            end
            KIND_PHASE: begin
                if (mode_i == 2'h1) begin
                    if (hit && is_chan_a_i && wgm2_i) begin
                        wave_next = ~wave_o;
                    end
                end else if (mode_i[1]) begin
                    if (tick_i && at_top_i && cmp_is_top_i) begin
                        wave_next = mode_i[0];
                    end else if (hit) begin
                        wave_next = mode_i[0] ^ down_i;
                    end
                end
            end
            default: wave_next = wave_o;
        endcase
    end

    // Output level register.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wave_o <= 1'b0;
        end else begin
            wave_o <= wave_next;
        end
    end
endmodule

/* File: tb/timer8_waveform_output_control_asserts.sv */
`timescale 1ns/1ps
`include "timer8_waveform_regs.vh"
module timer8_waveform_output_control_asserts (
    input wire clk_i, // Clock.
    input wire rst_i, // Reset.
    input wire [2:0] addr_i, // Index.
    input wire [7:0] wdata_i, // Write data.
    input wire wr_i, // Write strobe.
    input wire rd_i, // Read strobe.
    input wire [7:0] port_a_i, // Port A.
    input wire [7:0] port_b_i, // Port B.
    input wire [7:0] rdata_o, // Read data.
    input wire pin_a_o, // Pin A.
    input wire pin_a_oe_n_o, // Enable A.
    input wire pin_b_o, // Pin B.
    input wire pin_b_oe_n_o, // Enable B.
    input wire waveform_out_a_o, // Wave A.
    input wire waveform_out_b_o // Wave B.
);
    reg [7:0] ctla_reg, ctlb_reg;
    reg [1:0] dir_reg;
    reg [2:0] quiet_reg;
    wire settled = quiet_reg >= 3'h3;
    // Mode 01 on A is cut off in PWM unless bit 2 is set.
    wire a_conn = ctla_reg[7:6] != 2'b00 && !(ctla_reg[7:6] == 2'b01 && ctla_reg[0] && !ctlb_reg[3]);
    // Shadow copies of the writes; quiet counts cycles since the last one, so pipelines drain.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctla_reg <= 8'h00;
            ctlb_reg <= 8'h00;
            dir_reg <= 2'h0;
            quiet_reg <= 3'h0;
        end else if (wr_i) begin
            quiet_reg <= 3'h0;
            if (addr_i == `ADDR_CONTROL_A) ctla_reg <= wdata_i & 8'hf3;
            if (addr_i == `ADDR_CONTROL_B) ctlb_reg <= wdata_i & 8'h09;
            if (addr_i == `ADDR_DIRECTION) dir_reg <= wdata_i[1:0];
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not zero");
    a_ctla_read_masked: assert property ($past(rd_i) && $past(addr_i) == 3'h0 |-> rdata_o == ctla_reg) else $error("control A readback wrong");
    a_ctlb_read_masked: assert property ($past(rd_i) && $past(addr_i) == 3'h1 |-> rdata_o == ctlb_reg) else $error("control B readback wrong");
    a_pin_a_enable: assert property (settled |-> pin_a_oe_n_o == !dir_reg[0]) else $error("pin A enable wrong");
    a_pin_b_enable: assert property (settled |-> pin_b_oe_n_o == !dir_reg[1]) else $error("pin B enable wrong");
    a_pin_a_wave: assert property (settled && a_conn |-> pin_a_o == waveform_out_a_o) else $error("pin A not wave");
    a_pin_b_wave: assert property (settled && ctla_reg[5:4] != 2'b00 |-> pin_b_o == waveform_out_b_o) else $error("pin B not wave");
    a_pin_a_port: assert property (settled && !a_conn |=> pin_a_o == $past(port_a_i[0])) else $error("pin A not port");
    a_wave_stopped_hold: assert property (settled && !ctlb_reg[0] |=> $stable(waveform_out_a_o) && $stable(waveform_out_b_o)) else $error("wave moved while stopped");
    cover property (settled && ctla_reg[0] && $rose(waveform_out_a_o));
    cover property ($past(rd_i) && $past(addr_i) == 3'h0 && rdata_o != 8'h00);
    cover property (settled && !pin_b_oe_n_o && $fell(waveform_out_b_o));
endmodule
bind timer8_waveform_output_control timer8_waveform_output_control_asserts chk_u (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .port_a_i(port_a_i), .port_b_i(port_b_i), .rdata_o(rdata_o), .pin_a_o(pin_a_o),
    .pin_a_oe_n_o(pin_a_oe_n_o), .pin_b_o(pin_b_o), .pin_b_oe_n_o(pin_b_oe_n_o),
    .waveform_out_a_o(waveform_out_a_o), .waveform_out_b_o(waveform_out_b_o));

/* File: tb/timer8_waveform_output_control_bench.sv */
`timescale 1ns/1ps
module timer8_waveform_output_control_bench;
    reg clk_i, rst_i, wr_i, rd_i;
    reg [2:0] addr_i;
    reg [7:0] wdata_i, port_a_i, port_b_i, v;
    wire [7:0] rdata_o;
    wire pa, pa_oe_n, pb, pb_oe_n, wa, wb;
    integer error_cnt, num_checks, i;
    timer8_waveform_output_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .port_a_i(port_a_i), .port_b_i(port_b_i),
        .rdata_o(rdata_o), .pin_a_o(pa), .pin_a_oe_n_o(pa_oe_n), .pin_b_o(pb),
        .pin_b_oe_n_o(pb_oe_n), .waveform_out_a_o(wa), .waveform_out_b_o(wb));
    // The clock runs at 20 MHz.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task check8(input string n, input [7:0] e, input [7:0] s);
        begin
            num_checks = num_checks + 1;
            if (s !== e) begin
                $display("unexpected %s expected %h seen %h", n, e, s);
                error_cnt = error_cnt + 1;
            end
        end
    endtask
    task check1(input string n, input e, input s);
        begin
            check8(n, {7'h00, e}, {7'h00, s});
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    // Read data are taken mid-cycle, in the one cycle where they stand.
    task rd(input [2:0] a);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            @(negedge clk_i);
            v = rdata_o;
        end
    endtask
    // The timer ticks every clock while run is set; outputs are judged once it has stopped.
    task run(input integer n);
        begin
            wr(3'h1, 8'h01);
            repeat (n) @(posedge clk_i);
            wr(3'h1, 8'h00);
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
        end
    endtask
    task t_reset_and_masks;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rd(i);
                check8("reset value", 8'h00, v);
            end
            wr(3'h0, 8'hff);
            rd(3'h0);
            check8("control A", 8'hf3, v);
            wr(3'h1, 8'hff);
            rd(3'h1);
            check8("control B", 8'h09, v);
            wr(3'h1, 8'h00);
            wr(3'h0, 8'h00);
        end
    endtask
    task t_pins;
        begin
            port_a_i <= 8'h01;
            wr(3'h6, 8'h01);
            repeat (3) @(negedge clk_i);
            check1("enable A", 1'b0, pa_oe_n);
            check1("enable B", 1'b1, pb_oe_n);
            check1("port A", 1'b1, pa);
            wr(3'h6, 8'h03);
        end
    endtask
    // Both channels share a mode; the match at 0x12 is passed once per run.
    task t_non_pwm(input [1:0] m, input e);
        begin
            wr(3'h0, {m, m, 4'h0});
            wr(3'h2, 8'h10);
            run(6);
            check1("wave A", e, wa);
            check1("wave B", e, wb);
            check1("pin A", e, pa);
        end
    endtask
    task t_flags;
        begin
            wr(3'h0, 8'h00);
            wr(3'h2, 8'hfd);
            run(6);
            rd(3'h5);
            check1("overflow normal", 1'b1, v[0]);
            wr(3'h5, 8'h07);
            rd(3'h5);
            check1("overflow cleared", 1'b0, v[0]);
            wr(3'h0, 8'h02);
            wr(3'h3, 8'h20);
            wr(3'h2, 8'h1e);
            run(6);
            rd(3'h5);
            check1("overflow clear-on-match", 1'b0, v[0]);
            rd(3'h2);
            check1("wrap at compare A", 1'b1, v < 8'h20);
        end
    endtask
    task t_fast;
        begin
            wr(3'h0, 8'h00);
            wr(3'h3, 8'h80);
            wr(3'h4, 8'h80);
            wr(3'h0, 8'hb3);
            wr(3'h2, 8'h7e);
            run(5);
            check1("fast match A", 1'b0, wa);
            check1("fast match B", 1'b1, wb);
            wr(3'h2, 8'hfd);
            run(5);
            check1("fast top A", 1'b1, wa);
            check1("fast top B", 1'b0, wb);
            wr(3'h2, 8'h10);
            wr(3'h3, 8'h20);
            run(24);
            check1("buffered compare", 1'b1, wa);
            wr(3'h0, 8'h53);
            port_a_i <= 8'h00;
            repeat (3) @(negedge clk_i);
            check1("mode 01 port", 1'b0, pa);
        end
    endtask
    task t_phase;
        begin
            wr(3'h0, 8'h00);
            wr(3'h3, 8'h80);
            wr(3'h4, 8'h80);
            wr(3'h0, 8'hb1);
            wr(3'h2, 8'h7e);
            run(5);
            check1("phase up A", 1'b0, wa);
            check1("phase up B", 1'b1, wb);
            run(256);
            check1("phase down A", 1'b1, wa);
            check1("phase down B", 1'b0, wb);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // A hang is cut short and counted against the run.
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt = error_cnt + 1;
        summarize;
    end
    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        port_a_i = 8'h00;
        port_b_i = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_and_masks;
        t_pins;
        wr(3'h3, 8'h12);
        wr(3'h4, 8'h12);
        t_non_pwm(2'b11, 1'b1);
        t_non_pwm(2'b10, 1'b0);
        t_non_pwm(2'b01, 1'b1);
        t_non_pwm(2'b01, 1'b0);
        t_flags;
        t_fast;
        t_phase;
        summarize;
    end
endmodule
